/* File: rtl/fsg_pkg.sv */
// package: register map, field layout, reset values and state codes of the frame sync generator
package fsg_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] FSG_IDX_CTRL    = 8'h18;
   localparam logic [7:0] FSG_IDX_HI_UP   = 8'h19;
   localparam logic [7:0] FSG_IDX_HI_LO   = 8'h1a;
   localparam logic [7:0] FSG_IDX_LO_UP   = 8'h1b;
   localparam logic [7:0] FSG_IDX_LO_LO   = 8'h1c;
   localparam logic [7:0] FSG_IDX_STATUS  = 8'h3f;
   localparam int         FSG_ADDR_W      = 8;

   localparam logic [9:0] FSG_ADDR_CTRL   = {FSG_IDX_CTRL, 2'b00};
   localparam logic [9:0] FSG_ADDR_HI_UP  = {FSG_IDX_HI_UP, 2'b00};
   localparam logic [9:0] FSG_ADDR_HI_LO  = {FSG_IDX_HI_LO, 2'b00};
   localparam logic [9:0] FSG_ADDR_LO_UP  = {FSG_IDX_LO_UP, 2'b00};
   localparam logic [9:0] FSG_ADDR_LO_LO  = {FSG_IDX_LO_LO, 2'b00};
   localparam logic [9:0] FSG_ADDR_STATUS = {FSG_IDX_STATUS, 2'b00};

   // control register fields
   localparam int FSG_CTRL_SRC_HI   = 7;
   localparam int FSG_CTRL_SRC_LO   = 4;
   localparam int FSG_CTRL_SHOT     = 3;
   localparam int FSG_CTRL_IDLE     = 2;
   localparam int FSG_CTRL_SPLIT    = 1;
   localparam int FSG_CTRL_EN       = 0;

   // status register fields
   localparam int FSG_STAT_OUT      = 0;
   localparam int FSG_STAT_BUSY     = 1;
   localparam int FSG_STAT_HIGH     = 2;
   localparam int FSG_STAT_EXT      = 3;

   // reset values
   localparam logic [7:0] FSG_RST_CTRL  = 8'h00;
   localparam logic [7:0] FSG_RST_BYTE  = 8'h00;

   // synchroniser lanes: four back-channel frame clocks, the fast reference, eight gpio
   localparam int FSG_BC_N     = 4;
   localparam int FSG_GPIO_N   = 8;
   localparam int FSG_LANE_REF = 4;
   localparam int FSG_LANE_GP  = 5;
   localparam int FSG_SYNC_W   = FSG_BC_N + 1 + FSG_GPIO_N;
   localparam int FSG_CNT_W    = 24;

   typedef enum logic [3:0] {
      FSG_ST_IDLE = 4'h1,
      FSG_ST_HIGH = 4'h2,
      FSG_ST_LOW  = 4'h4,
      FSG_ST_SHOT = 4'h8
   } fsg_state_t;

endpackage : fsg_pkg

/* File: rtl/fsg_edge_if.sv */
// interface: synchronised levels and rising-edge strobes handed to the generator
`timescale 1ns/100ps
`default_nettype none
interface fsg_edge_if #(parameter int W = 13);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   modport src (output lvl, output rise);
   modport dst (input lvl, input rise);
endinterface : fsg_edge_if
`default_nettype wire

/* File: rtl/fsg_sync_edge.sv */
// module: two-flop synchroniser with rising-edge strobe for each input lane
`timescale 1ns/100ps
`default_nettype none
module fsg_sync_edge #(
   parameter int W = 13
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // asynchronous lanes
   input  wire logic [W-1:0] async_in,
   // synchronised result
   fsg_edge_if.src           eo
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;

   // meta_reg is read by sync_reg alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= sync_reg;
      end
   end

   assign eo.lvl  = sync_reg;
   assign eo.rise = sync_reg & ~prev_reg;

endmodule : fsg_sync_edge
`default_nettype wire

/* File: rtl/fsg_frame_sync_gen.sv */
// module: programmable frame sync generator with apb register slave
//
// Behaviour
// [R1] Source codes 0000 to 0011 run the internal generator on the back-channel frame clock of port 0 to 3.
// [R2] Source codes 01xx run the internal generator on the fast 25 MHz reference.
// [R3] Source codes 1000 to 1111 pass gpio 0 to 7 through as the frame sync.
// [R4] Writing one to control bit 3 emits exactly one frame sync pulse; the code drops the trigger while an external source is selected.
// [R5] The one-shot bit clears itself and always reads zero.
// [R6] Software waits out the whole pulse before triggering another one-shot.
// [R7] Software keeps periodic generation off while using one-shot pulses.
// [R8] Control bit 2 sets the initial level of the frame sync output.
// [R9] Control bit 1 picks separate high and low lengths (0) or a 50/50 split (1).
// [R10] In high/low mode the high phase uses the 16-bit high length and the low phase the 16-bit low length.
// [R11] In 50/50 mode one 24-bit length from the high lower byte and both low bytes times both phases.
// [R12] Control bit 0 turns continuous internal generation off (0) or on (1).
// [R13] High length is cycles minus one, bits 15:8 at index 0x19 and bits 7:0 at index 0x1a.
// [R14] Low length is cycles minus one, bits 15:8 at index 0x19 plus two, that is 0x1b.
// [R15] Low length bits 7:0 sit at index 0x1c and reset to zero.
// [R16] When enabled internally the output starts at the initial level and alternates phases counting reference ticks.
// [R17] In an external mode the output follows the synchronised level of the chosen gpio.
`timescale 1ns/100ps
`default_nettype none
module fsg_frame_sync_gen
   import fsg_pkg::*;
(
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [FSG_ADDR_W+1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // timing references and external sources
   input  wire logic [FSG_BC_N-1:0]   bc_frame_clk,
   input  wire logic                  ref_fast_clk,
   input  wire logic [FSG_GPIO_N-1:0] gpio_in,
   // frame sync toward the serializers
   output logic                       frame_sync_out
);

   ////////////////////////////////////////////////////////////////////////////
   // registers and state

   logic [7:0]           ctrl_reg;
   logic [7:0]           hi_up_reg;
   logic [7:0]           hi_lo_reg;
   logic [7:0]           lo_up_reg;
   logic [7:0]           lo_lo_reg;
   logic                 shot_reg;
   fsg_state_t           state_reg;
   logic [FSG_CNT_W-1:0] cnt_reg;
   logic                 out_reg;
   logic                 pready_reg;
   logic                 pslverr_reg;
   logic [31:0]          prdata_reg;

   logic                 setup;
   logic                 wr_en;
   logic                 addr_ok;
   logic [7:0]           rd_byte;
   logic [3:0]           src_sel;
   logic                 ext_mode;
   logic                 tick;
   logic                 gpio_lvl;
   logic [FSG_CNT_W-1:0] len_high;
   logic [FSG_CNT_W-1:0] len_low;
   logic                 idle_lvl;
   logic                 gen_on;
   logic                 ctrl_wr;
   logic                 shot_go;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   fsg_edge_if #(.W(FSG_SYNC_W)) edges ();

   fsg_sync_edge #(.W(FSG_SYNC_W)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({gpio_in, ref_fast_clk, bc_frame_clk}),
      .eo       (edges)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control decode

   assign src_sel  = ctrl_reg[FSG_CTRL_SRC_HI:FSG_CTRL_SRC_LO];
   assign ext_mode = src_sel[3];
   assign idle_lvl = ctrl_reg[FSG_CTRL_IDLE];
   assign gen_on   = ctrl_reg[FSG_CTRL_EN] && !ext_mode;        // see [R12]
   assign gpio_lvl = edges.lvl[FSG_LANE_GP + int'(src_sel[2:0])]; // see [R3]

   // a pending one-shot fires only on a tick, so its pulse always spans whole ticks
   assign shot_go  = shot_reg && tick && !ext_mode;             // see [R4]

   // the reference is sampled on pclk, so only its rising edges that pclk can resolve are counted
   always_comb begin
      if (src_sel[2]) begin
         tick = edges.rise[FSG_LANE_REF];                       // see [R2]
      end else begin
         tick = edges.rise[src_sel[1:0]];                       // see [R1]
      end
   end

   // phase lengths, stored as cycles minus one
   always_comb begin
      if (ctrl_reg[FSG_CTRL_SPLIT]) begin
         len_high = {hi_lo_reg, lo_up_reg, lo_lo_reg};          // see [R9] [R11]
         len_low  = {hi_lo_reg, lo_up_reg, lo_lo_reg};
      end else begin
         len_high = {8'h00, hi_up_reg, hi_lo_reg};              // see [R10] [R13]
         len_low  = {8'h00, lo_up_reg, lo_lo_reg};              // see [R10] [R14] [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: no wait state, answer registered in the setup cycle

   assign setup   = psel && !penable;
   assign wr_en   = psel && penable && pready_reg && pwrite && pstrb[0] && !pslverr_reg;
   // control writes also carry the one-shot trigger
   assign ctrl_wr = wr_en && (paddr == FSG_ADDR_CTRL);
   assign addr_ok = (paddr == FSG_ADDR_CTRL)  || (paddr == FSG_ADDR_HI_UP) ||
                    (paddr == FSG_ADDR_HI_LO) || (paddr == FSG_ADDR_LO_UP) ||
                    (paddr == FSG_ADDR_LO_LO) || (paddr == FSG_ADDR_STATUS);

   always_comb begin
      rd_byte = 8'h00;
      case (paddr)
         FSG_ADDR_CTRL:   rd_byte = ctrl_reg & ~(8'h01 << FSG_CTRL_SHOT); // see [R5]
         FSG_ADDR_HI_UP:  rd_byte = hi_up_reg;
         FSG_ADDR_HI_LO:  rd_byte = hi_lo_reg;
         FSG_ADDR_LO_UP:  rd_byte = lo_up_reg;
         FSG_ADDR_LO_LO:  rd_byte = lo_lo_reg;
         FSG_ADDR_STATUS: begin
            rd_byte[FSG_STAT_OUT]  = out_reg;
            rd_byte[FSG_STAT_BUSY] = (state_reg != FSG_ST_IDLE);
            rd_byte[FSG_STAT_HIGH] = (state_reg == FSG_ST_HIGH);
            rd_byte[FSG_STAT_EXT]  = ext_mode;
         end
         default:         rd_byte = 8'h00;
      endcase
   end

   // ready answers every setup in the next cycle, so no access ever has a wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
      end
   end

   // error and data are captured with ready; error stands for the access cycle only, data holds until the next setup
   // a read of status is a snapshot taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (setup) begin
         pslverr_reg <= !addr_ok;
         prdata_reg  <= {24'h00_0000, rd_byte};
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   // control byte; the one-shot bit is never stored, so it always reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= FSG_RST_CTRL;
      end else if (ctrl_wr) begin
         ctrl_reg <= pwdata[7:0] & ~(8'h01 << FSG_CTRL_SHOT); // see [R5]
      end
   end

   // length bytes; read-only status writes are dropped without error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_up_reg <= FSG_RST_BYTE;
         hi_lo_reg <= FSG_RST_BYTE;
         lo_up_reg <= FSG_RST_BYTE;
         lo_lo_reg <= FSG_RST_BYTE;
      end else if (wr_en) begin
         case (paddr)
            FSG_ADDR_HI_UP: hi_up_reg <= pwdata[7:0];          // see [R13]
            FSG_ADDR_HI_LO: hi_lo_reg <= pwdata[7:0];          // see [R13]
            FSG_ADDR_LO_UP: lo_up_reg <= pwdata[7:0];          // see [R14]
            FSG_ADDR_LO_LO: lo_lo_reg <= pwdata[7:0];          // see [R15]
            default: ;
         endcase
      end
   end

   // trigger is held until the next tick; dropped while busy, enabled or external
   // a new trigger wins over the clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shot_reg <= 1'b0;
      end else if (ctrl_wr && pwdata[FSG_CTRL_SHOT]) begin
         shot_reg <= 1'b1;                                      // see [R4] [R5]
      end else if (tick || gen_on || ext_mode || (state_reg != FSG_ST_IDLE)) begin
         shot_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // generator

   // a trigger while busy is dropped; software must wait the pulse out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= FSG_ST_IDLE;
         cnt_reg   <= '0;
      end else begin
         case (state_reg)
            FSG_ST_IDLE: begin
               if (gen_on) begin
                  state_reg <= idle_lvl ? FSG_ST_HIGH : FSG_ST_LOW; // see [R8] [R16]
                  cnt_reg   <= idle_lvl ? len_high : len_low;
               end else if (shot_go) begin
                  // pulse takes the level and length of the phase opposite the idle level
                  state_reg <= FSG_ST_SHOT;                         // see [R4] [R7]
                  cnt_reg   <= idle_lvl ? len_low : len_high;
               end
            end
            FSG_ST_HIGH: begin
               if (!gen_on) begin
                  state_reg <= FSG_ST_IDLE;                         // see [R12]
               end else if (tick) begin
                  if (cnt_reg == '0) begin
                     state_reg <= FSG_ST_LOW;                       // see [R16]
                     cnt_reg   <= len_low;
                  end else begin
                     cnt_reg   <= cnt_reg - 1'b1;
                  end
               end
            end
            FSG_ST_LOW: begin
               if (!gen_on) begin
                  state_reg <= FSG_ST_IDLE;
               end else if (tick) begin
                  if (cnt_reg == '0) begin
                     state_reg <= FSG_ST_HIGH;                      // see [R16]
                     cnt_reg   <= len_high;
                  end else begin
                     cnt_reg   <= cnt_reg - 1'b1;
                  end
               end
            end
            FSG_ST_SHOT: begin
               if (ext_mode) begin
                  state_reg <= FSG_ST_IDLE;
               end else if (tick) begin
                  if (cnt_reg == '0) begin
                     state_reg <= FSG_ST_IDLE;                      // see [R4] [R6]
                  end else begin
                     cnt_reg   <= cnt_reg - 1'b1;
                  end
               end
            end
            default: begin
               state_reg <= FSG_ST_IDLE;
               cnt_reg   <= '0;
            end
         endcase
      end
   end

   // output flop: external level, or the level of the current phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg <= 1'b0;
      end else if (ext_mode) begin
         out_reg <= gpio_lvl;                                   // see [R17]
      end else begin
         case (state_reg)
            FSG_ST_HIGH: out_reg <= 1'b1;
            FSG_ST_LOW:  out_reg <= 1'b0;
            FSG_ST_SHOT: out_reg <= !idle_lvl;                  // see [R4]
            default:     out_reg <= idle_lvl;                   // see [R8]
         endcase
      end
   end

   // every output is a flop with nothing between it and the pin,
   // so the far side never sees a combinational glitch
   assign frame_sync_out = out_reg;
   assign pready         = pready_reg;
   assign pslverr        = pslverr_reg;
   assign prdata         = prdata_reg;

endmodule : fsg_frame_sync_gen
`default_nettype wire

/* File: sim/fsg_chk_sva.sv */
// checker: apb timing, readback and output level properties of the frame sync generator
`timescale 1ns/100ps
`default_nettype none
module fsg_chk
   import fsg_pkg::*;
(
   // clock and reset
   input wire logic                  pclk,
   input wire logic                  presetn,
   // apb
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [FSG_ADDR_W+1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic                  pready,
   input wire logic [31:0]           prdata,
   input wire logic                  pslverr,
   // sources and output
   input wire logic [FSG_GPIO_N-1:0] gpio_in,
   input wire logic                  frame_sync_out
);
   logic [7:0] sh_reg [5];
   logic       hit;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign hit = paddr >= FSG_ADDR_CTRL && paddr <= FSG_ADDR_LO_LO && paddr[1:0] == 2'b00;
   // shadow of written bytes, so the mode is known without looking inside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sh_reg <= '{default: 8'h00};
      else if (psel && penable && pready && pwrite && pstrb[0] && hit) sh_reg[paddr[4:2]] <= pwdata[7:0];
   end
   a_wait_one: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_read_back: assert property (pready && !pwrite && hit |->
      prdata == {24'h0, sh_reg[paddr[4:2]] & ((paddr[4:2] == 3'd0) ? 8'hf7 : 8'hff)})
      else $error("read data differs from written byte");
   a_err_unmapped: assert property (pready && !hit && paddr != FSG_ADDR_STATUS |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (pready && hit |-> !pslverr)
      else $error("error on mapped register");
   a_ext_follow: assert property (sh_reg[0][7] && $past(sh_reg[0], 4) == sh_reg[0] |->
      frame_sync_out == $past(gpio_in[sh_reg[0][6:4]], 3))
      else $error("output does not follow gpio");
   a_start_idle: assert property ($rose(sh_reg[0][0]) && !sh_reg[0][7] |-> ##2 frame_sync_out == sh_reg[0][2])
      else $error("start not at idle level");
   a_stop_idle: assert property ($fell(sh_reg[0][0]) && !sh_reg[0][7] |-> ##2 frame_sync_out == sh_reg[0][2])
      else $error("stop not at idle level");
endmodule : fsg_chk
bind fsg_frame_sync_gen fsg_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .pready, .prdata, .pslverr, .gpio_in, .frame_sync_out);
`default_nettype wire

/* File: sim/fsg_src_model.sv */
// model: far-side reference clocks and gpio sources feeding the generator
`timescale 1ns/100ps
`default_nettype none
module fsg_src_model
   import fsg_pkg::*;
#(
   parameter int HALF = 2
) (
   // clock
   input  wire logic                  pclk,
   // gpio level asked for by the bench
   input  wire logic [FSG_GPIO_N-1:0] gpio_want,
   // lines into the generator
   output logic [FSG_BC_N-1:0]        bc_frame_clk,
   output logic                       ref_fast_clk,
   output logic [FSG_GPIO_N-1:0]      gpio_in
);
   int                    cnt [5] = '{default: 0};
   logic [FSG_BC_N-1:0]   bc_reg  = '0;
   logic                  ref_reg = 1'b0;
   logic [FSG_GPIO_N-1:0] gp_reg  = '0;
   assign bc_frame_clk = bc_reg;
   assign ref_fast_clk = ref_reg;
   assign gpio_in      = gp_reg;
   // every clock lane has its own rate, so a wrong source pick shows as a wrong width
   always @(posedge pclk) begin
      gp_reg <= gpio_want;
      for (int k = 0; k < 5; k++) begin
         cnt[k] <= (cnt[k] + 1) % (HALF + k);
         if (cnt[k] == HALF + k - 1) begin
            if (k < 4) bc_reg[k] <= !bc_reg[k];
            else ref_reg <= !ref_reg;
         end
      end
   end
endmodule : fsg_src_model
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: register, periodic, one-shot and external checks of the frame sync generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import fsg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_fast_clk, frame_sync_out, er;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0]  pstrb, bc_frame_clk;
   logic [7:0]  gpio_in, gpio_want, hl, ll;
   int          n_fail, samples_checked, cyc, n, per, mdl [5];
   fsg_frame_sync_gen dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .bc_frame_clk, .ref_fast_clk, .gpio_in, .frame_sync_out);
   fsg_src_model #(.HALF(2)) u_src (.pclk, .gpio_want, .bc_frame_clk, .ref_fast_clk, .gpio_in);
   initial pclk = 1'b0;
   always #50 pclk = !pclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(logic w, logic [9:0] a, logic [7:0] d, output logic [31:0] r, output logic e);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // ready is sampled at the rising edge; the request stands until then
      for (t = 0; t < 20; t++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("ready", 1, t < 20);
   endtask : apb
   task automatic wr(logic [9:0] a, logic [7:0] d);
      apb(1'b1, a, d, rd, er);
      mdl[a[4:2]] = d & ((a == FSG_ADDR_CTRL) ? 8'hf7 : 8'hff);
   endtask : wr
   task automatic rchk(int i);
      apb(1'b0, FSG_ADDR_CTRL + 10'(4 * i), 8'h00, rd, er);
      chk("reg", mdl[i], rd);
      chk("err", 0, er);
   endtask : rchk
   // cycles of the next whole phase at level lvl
   task automatic width(logic lvl, output int w);
      w = 0;
      while (frame_sync_out !== !lvl && w < 999) begin
         @(negedge pclk);
         w++;
      end
      while (frame_sync_out !== lvl && w < 999) begin
         @(negedge pclk);
         w++;
      end
      w = 0;
      while (frame_sync_out === lvl && w < 999) begin
         @(negedge pclk);
         w++;
      end
   endtask : width
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, gpio_want} = '0;
      pstrb = 4'hf;
      seed = 32'hc56e;
      mdl = '{default: 0};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) rchk(i);
      $display("reset values done");
      for (int s = 0; s < 8; s++) begin
         hl = 8'(rnd() % 4);
         ll = 8'(rnd() % 4);
         // one reference tick lasts two half periods of the chosen lane
         per = 2 * (2 + ((s < 4) ? s : 4));
         wr(FSG_ADDR_HI_LO, hl);
         wr(FSG_ADDR_LO_LO, ll);
         wr(FSG_ADDR_CTRL, 8'(s << 4) | 8'h01);
         width(1'b1, n);
         chk("high", (hl + 1) * per, n);
         width(1'b0, n);
         chk("low", (ll + 1) * per, n);
         wr(FSG_ADDR_CTRL, 8'h00);
      end
      $display("periodic done");
      wr(FSG_ADDR_HI_UP, 8'hff);
      wr(FSG_ADDR_HI_LO, 8'h00);
      wr(FSG_ADDR_LO_LO, 8'h02);
      wr(FSG_ADDR_CTRL, 8'h43);
      width(1'b1, n);
      chk("half high", 36, n);
      width(1'b0, n);
      chk("half low", 36, n);
      wr(FSG_ADDR_CTRL, 8'h40);
      wr(FSG_ADDR_HI_UP, 8'h00);
      $display("split done");
      for (int v = 0; v < 2; v++) begin
         wr(FSG_ADDR_CTRL, 8'(v << 2) | 8'h40);
         repeat (3) @(negedge pclk);
         chk("idle", v, frame_sync_out);
         wr(FSG_ADDR_CTRL, 8'(v << 2) | 8'h48);
         width(!v[0], n);
         chk("shot", v ? 36 : 12, n);
         n = 0;
         repeat (150) begin
            @(negedge pclk);
            n += (frame_sync_out !== v[0]);
         end
         chk("extra", 0, n);
         rchk(0);
      end
      $display("one-shot done");
      for (int s = 8; s < 16; s++) begin
         wr(FSG_ADDR_CTRL, 8'(s << 4));
         repeat (3) begin
            @(posedge pclk);
            gpio_want <= 8'(rnd());
            repeat (6) @(negedge pclk);
            chk("ext", gpio_want[s - 8], frame_sync_out);
         end
      end
      $display("external done");
      for (int i = 0; i < 5; i++) begin
         wr(FSG_ADDR_CTRL + 10'(4 * i), 8'(rnd()) & ((i == 0) ? 8'hf6 : 8'hff));
         rchk(i);
      end
      // a write without its low byte strobe must leave the register alone
      pstrb <= 4'he;
      apb(1'b1, FSG_ADDR_HI_UP, 8'h5a, rd, er);
      pstrb <= 4'hf;
      rchk(1);
      apb(1'b1, 10'h074, 8'h5a, rd, er);
      chk("err", 1, er);
      apb(1'b0, 10'h061, 8'h00, rd, er);
      chk("err", 1, er);
      chk("rd", 0, rd);
      apb(1'b0, FSG_ADDR_STATUS, 8'h00, rd, er);
      chk("err", 0, er);
      chk("stat ext", (mdl[0] >> 7) & 1, (rd >> 3) & 1);
      $display("registers done");
      close_out();
   end
endmodule : testbench
`default_nettype wire
